/* include/pxs_cfg_if.sv */
// configuration and status carried between register file and sequencer
`default_nettype none
interface pxs_cfg_if;
  logic [7:0] function_enable;
  logic [7:0] integration_time;
  logic [7:0] wait_time;
  logic [15:0] low_threshold;
  logic [15:0] high_threshold;
  logic [7:0] interrupt_filter;
  logic [7:0] configuration;
  logic [7:0] pulse_count;
  logic [7:0] status;

  modport regs (
    output function_enable, integration_time, wait_time, low_threshold,
    output high_threshold, interrupt_filter, configuration, pulse_count,
    input status
  );
  modport seq (
    input function_enable, integration_time, wait_time, low_threshold,
    input high_threshold, interrupt_filter, configuration, pulse_count,
    output status
  );
endinterface : pxs_cfg_if
`default_nettype wire

/* include/pxs_pkg.sv */
// shared constants and types of the proximity sequencer
`default_nettype none
package pxs_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ = 200_000_000;
  localparam int STEP_TIME_NS = 2_730_000;
  // least time: round up to whole cycles
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_RATE_HZ = 62_500;
  localparam int PULSE_CYCLES = CLK_HZ / PULSE_RATE_HZ;
  localparam logic [11:0] STEP_SPAN = 12'h100;
  localparam logic [11:0] WAIT_LONG_MULT = 12'h00C;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_ENABLE = 5'h00;
  localparam logic [4:0] ADDR_ITIME = 5'h02;
  localparam logic [4:0] ADDR_WAIT_TIME = 5'h03;
  localparam logic [4:0] ADDR_LOW_LO = 5'h08;
  localparam logic [4:0] ADDR_LOW_HI = 5'h09;
  localparam logic [4:0] ADDR_HIGH_LO = 5'h0A;
  localparam logic [4:0] ADDR_HIGH_HI = 5'h0B;
  localparam logic [4:0] ADDR_FILTER = 5'h0C;
  localparam logic [4:0] ADDR_CONFIG = 5'h0D;
  localparam logic [4:0] ADDR_PULSE = 5'h0E;
  localparam logic [4:0] ADDR_STATUS = 5'h13;
  localparam logic [4:0] CMD_IRQ_CLEAR = 5'h05;
  localparam int REG_SLOTS = 16;

  // ---------------------------------------------------------------
  // fields, masks and reset values
  // ---------------------------------------------------------------
  localparam int BIT_OSC_ON = 0;
  localparam int BIT_SENSE_EN = 2;
  localparam int BIT_WAIT_EN = 3;
  localparam int BIT_IRQ_MASK = 5;
  localparam int BIT_SLEEP = 6;
  localparam int BIT_WAIT_X12 = 1;
  localparam int FILT_LSB = 4;
  localparam int STAT_IRQ_BIT = 5;
  localparam int STAT_VALID_BIT = 1;
  localparam logic [7:0] MASK_ENABLE = 8'h6D;
  localparam logic [7:0] MASK_FILTER = 8'hF0;
  localparam logic [7:0] MASK_CONFIG = 8'h02;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] RST_TIME = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // sequencer states
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_BURST = 5'h02,
    S_INTEG = 5'h04,
    S_EVAL = 5'h08,
    S_WAIT = 5'h10
  } pxs_state_t;
endpackage : pxs_pkg
`default_nettype wire

/* rtl/pxs_regs.sv */
// register file written and read over the byte-wide register port
`default_nettype none
module pxs_regs
  import pxs_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [4:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // configuration out, status in
  pxs_cfg_if.regs cfg
);
  // writable bits per slot; reserved bits store and read as zero
  function automatic logic [7:0] slot_mask(input logic [4:0] a);
    unique case (a)
      ADDR_ENABLE: slot_mask = MASK_ENABLE;
      ADDR_FILTER: slot_mask = MASK_FILTER;
      ADDR_CONFIG: slot_mask = MASK_CONFIG;
      ADDR_ITIME, ADDR_WAIT_TIME, ADDR_PULSE: slot_mask = MASK_FULL;
      ADDR_LOW_LO, ADDR_LOW_HI, ADDR_HIGH_LO, ADDR_HIGH_HI: slot_mask = MASK_FULL;
      default: slot_mask = MASK_NONE;
    endcase
  endfunction : slot_mask

  function automatic logic [7:0] slot_reset(input logic [4:0] a);
    slot_reset = ((a == ADDR_ITIME) || (a == ADDR_WAIT_TIME)) ? RST_TIME : RST_ZERO;
  endfunction : slot_reset

  logic [7:0] store [REG_SLOTS];
  logic [7:0] next_rd_data;

  // ---------------------------------------------------------------
  // storage slots
  // ---------------------------------------------------------------
  for (genvar i = 0; i < REG_SLOTS; i++) begin : g_slot
    localparam logic [4:0] A = 5'(i);
    logic [7:0] next_val;
    always_comb begin
      next_val = store[i];
      if (i_wr_en && (i_wr_addr == A)) begin
        next_val = i_wr_data & slot_mask(A);
      end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        store[i] <= slot_reset(A);
      end else begin
        store[i] <= next_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // read path, unmapped addresses answer zero
  // ---------------------------------------------------------------
  always_comb begin
    next_rd_data = o_rd_data;
    if (i_rd_en) begin
      if (i_rd_addr == ADDR_STATUS) begin
        next_rd_data = cfg.status;
      end else begin
        next_rd_data = store[i_rd_addr[3:0]] & slot_mask(i_rd_addr);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= RST_ZERO;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  // field views for the sequencer
  assign cfg.function_enable = store[ADDR_ENABLE[3:0]];
  assign cfg.integration_time = store[ADDR_ITIME[3:0]];
  assign cfg.wait_time = store[ADDR_WAIT_TIME[3:0]];
  assign cfg.low_threshold = {store[ADDR_LOW_HI[3:0]], store[ADDR_LOW_LO[3:0]]};
  assign cfg.high_threshold = {store[ADDR_HIGH_HI[3:0]], store[ADDR_HIGH_LO[3:0]]};
  assign cfg.interrupt_filter = store[ADDR_FILTER[3:0]];
  assign cfg.configuration = store[ADDR_CONFIG[3:0]];
  assign cfg.pulse_count = store[ADDR_PULSE[3:0]];
endmodule : pxs_regs
`default_nettype wire

/* rtl/pxs_tick.sv */
// periodic one-cycle enable pulse from the system clock
`default_nettype none
module pxs_tick #(
  parameter int CYCLES = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_run,
  output logic o_tick
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // restart from zero whenever stopped, so each run gets a full first period
  always_comb begin
    next_cnt = cnt;
    if (!i_run) begin
      next_cnt = '0;
    end else if (cnt == LAST) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_tick = i_run && (cnt == LAST);
endmodule : pxs_tick
`default_nettype wire

/* rtl/pxs_top.sv */
// proximity measurement sequencer with configuration registers
`default_nettype none

module pxs_top
  import pxs_pkg::*;
#(
  parameter int P_STEP_CYCLES = STEP_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [4:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // special function command
  input wire logic i_special_valid,
  input wire logic [4:0] i_special_code,
  // conversion result from the analog channel
  input wire logic [15:0] i_prox_data,
  // analog and pin controls
  output logic o_osc_on,
  output logic o_led_pulse,
  output logic o_integrating,
  output logic o_irq
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  pxs_cfg_if cfg ();

  pxs_state_t state;
  pxs_state_t next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [11:0] cnt_inc;
  logic [11:0] integ_steps;
  logic [11:0] wait_steps;
  logic [11:0] wait_limit;
  logic [3:0] persist;
  logic [3:0] next_persist;
  logic [3:0] filt_n;
  logic pending;
  logic next_pending;
  logic valid;
  logic next_valid;
  logic led;
  logic next_led;
  logic integ;
  logic next_integ;
  logic eval;
  logic irq_evt;
  logic out_of_range;
  logic clear_cmd;
  logic osc_on;
  logic sense_en;
  logic wait_en;
  logic irq_mask;
  logic sleep_en;
  logic wait_x12;
  logic run_ok;
  logic hold;
  logic pulse_run;
  logic step_run;
  logic pulse_tick;
  logic step_tick;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  pxs_regs u_regs (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr_en(i_wr_en),
    .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data),
    .i_rd_en(i_rd_en),
    .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data),
    .cfg(cfg.regs)
  );

  // ---------------------------------------------------------------
  // control field decode
  // ---------------------------------------------------------------
  // oscillator power bit
  assign osc_on = cfg.function_enable[BIT_OSC_ON];
  assign sense_en = cfg.function_enable[BIT_SENSE_EN];
  assign wait_en = cfg.function_enable[BIT_WAIT_EN];
  assign irq_mask = cfg.function_enable[BIT_IRQ_MASK];
  assign sleep_en = cfg.function_enable[BIT_SLEEP];
  assign wait_x12 = cfg.configuration[BIT_WAIT_X12];
  assign filt_n = cfg.interrupt_filter[FILT_LSB +: 4];
  assign run_ok = osc_on && sense_en;
  assign clear_cmd = i_special_valid && (i_special_code == CMD_IRQ_CLEAR);

  assign integ_steps = STEP_SPAN - {4'h0, cfg.integration_time};
  // two's complement wait steps, 00 gives 256
  assign wait_steps = STEP_SPAN - {4'h0, cfg.wait_time};
  // long wait is twelve times longer
  assign wait_limit = wait_x12 ? (wait_steps * WAIT_LONG_MULT) : wait_steps;
  assign cnt_inc = cnt + 12'h001;

  // ---------------------------------------------------------------
  // time bases
  // ---------------------------------------------------------------
  // timers only run with oscillator on
  assign pulse_run = osc_on && (state == S_BURST);
  assign step_run = osc_on && ((state == S_INTEG) || (state == S_WAIT));

  // pulse spacing at the pulse rate
  pxs_tick #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_run(pulse_run),
    .o_tick(pulse_tick)
  );

  // step length is long; parameter lets simulation shrink it
  pxs_tick #(
    .CYCLES(P_STEP_CYCLES)
  ) u_step_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_run(step_run),
    .o_tick(step_tick)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // sleeping holds the sequencer while interrupt pends
  assign hold = sleep_en && pending;

  // burst, integrate, evaluate, optional wait, repeat
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_led = 1'b0;
    eval = 1'b0;
    if (!run_ok) begin
      next_state = S_IDLE;
      next_cnt = '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (!hold) begin
            next_state = S_BURST;
            next_cnt = '0;
          end
        end
        S_BURST: begin
          if (cnt == {4'h0, cfg.pulse_count}) begin
            next_state = S_INTEG;
            next_cnt = '0;
          end else if (pulse_tick) begin
            next_led = 1'b1;
            next_cnt = cnt_inc;
          end
        end
        S_INTEG: begin
          if (step_tick) begin
            next_cnt = cnt_inc;
            if (cnt_inc == integ_steps) begin
              next_state = S_EVAL;
              next_cnt = '0;
            end
          end
        end
        S_EVAL: begin
          eval = 1'b1;
          next_cnt = '0;
          next_state = wait_en ? S_WAIT : S_IDLE;
        end
        S_WAIT: begin
          if (step_tick) begin
            next_cnt = cnt_inc;
            if (cnt_inc == wait_limit) begin
              next_state = S_IDLE;
              next_cnt = '0;
            end
          end
        end
      endcase
    end
    next_integ = (next_state == S_INTEG);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= S_IDLE;
      cnt <= '0;
      led <= 1'b0;
      integ <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      led <= next_led;
      integ <= next_integ;
    end
  end

  // ---------------------------------------------------------------
  // threshold compare and persistence filter
  // ---------------------------------------------------------------
  // below low or above high is out of range
  assign out_of_range = (i_prox_data < cfg.low_threshold) ||
                        (i_prox_data > cfg.high_threshold);

  // counter saturates so a long run keeps qualifying
  always_comb begin
    next_persist = persist;
    irq_evt = 1'b0;
    if (!run_ok) begin
      next_persist = '0;
    end else if (eval) begin
      if (filt_n == 4'h0) begin
        irq_evt = 1'b1;
      end else if (out_of_range) begin
        next_persist = (persist == 4'hF) ? persist : (persist + 4'h1);
        irq_evt = (next_persist >= filt_n);
      end else begin
        next_persist = '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // pending interrupt and valid flag
  // ---------------------------------------------------------------
  always_comb begin
    next_pending = pending;
    // clear command drops the pending interrupt
    if (clear_cmd) begin
      next_pending = 1'b0;
    end
    // only a set mask raises; set wins over clear
    if (irq_evt && irq_mask) begin
      next_pending = 1'b1;
    end
    next_valid = valid;
    if (!sense_en) begin
      next_valid = 1'b0;
    end else if (eval) begin
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      persist <= '0;
      pending <= 1'b0;
      valid <= 1'b0;
    end else begin
      persist <= next_persist;
      pending <= next_pending;
      valid <= next_valid;
    end
  end

  // ---------------------------------------------------------------
  // status and outputs
  // ---------------------------------------------------------------
  // status shows the pending interrupt
  always_comb begin
    cfg.status = RST_ZERO;
    cfg.status[STAT_IRQ_BIT] = pending;
    cfg.status[STAT_VALID_BIT] = valid;
  end

  assign o_osc_on = osc_on;
  assign o_led_pulse = led;
  assign o_integrating = integ;
  assign o_irq = pending;
endmodule : pxs_top
`default_nettype wire

/* sim/pxs_analog_model.sv */
// analog channel stand-in feeding conversion results
`default_nettype none
module pxs_analog_model (
  // clock
  input wire logic i_clk,
  // level and timing
  input wire logic [15:0] i_level,
  input wire logic i_integrating,
  output logic [15:0] o_prox_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic int_q = 1'b0;
  // stretch by one cycle so the evaluation cycle still sees the result
  always @(posedge i_clk) int_q <= i_integrating;
  // result window
  // outside the window show the inverse, so a late sample reads wrong
  assign o_prox_data = (i_integrating || int_q) ? i_level : ~i_level;
endmodule : pxs_analog_model
`default_nettype wire

/* sim/pxs_checker.sv */
// port assertions for the proximity sequencer
`default_nettype none
module pxs_checker
  import pxs_pkg::*;
#(
  parameter int P_STEP_CYCLES = STEP_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [4:0] i_rd_addr,
  input wire logic [7:0] o_rd_data,
  // command and analog
  input wire logic i_special_valid,
  input wire logic [4:0] i_special_code,
  input wire logic [15:0] i_prox_data,
  // outputs
  input wire logic o_osc_on,
  input wire logic o_led_pulse,
  input wire logic o_integrating,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // shadows and timers
  // ---------------------------------------------------------------
  logic [7:0] en_q;
  logic [7:0] it_q;
  logic [15:0] gap;
  // wide enough for a full-length step at the real clock rate
  logic [27:0] ilen;
  logic clr;
  assign clr = i_special_valid && (i_special_code == CMD_IRQ_CLEAR);
  // gap saturates so the first pulse of a run never trips the spacing check
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q <= RST_ZERO;
      it_q <= RST_TIME;
      gap <= 16'hFFFF;
      ilen <= 28'h0000000;
    end else begin
      if (i_wr_en && i_wr_addr == ADDR_ENABLE) en_q <= i_wr_data;
      if (i_wr_en && i_wr_addr == ADDR_ITIME) it_q <= i_wr_data;
      gap <= o_led_pulse ? 16'h0000 : ((gap == 16'hFFFF) ? gap : gap + 16'h0001);
      ilen <= o_integrating ? ilen + 28'h0000001 : 28'h0000000;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_osc_follow;
    i_wr_en && i_wr_addr == ADDR_ENABLE |=> o_osc_on == $past(i_wr_data[BIT_OSC_ON]);
  endproperty
  a_osc_follow: assert property (p_osc_follow)
    else $error("oscillator output differs from written bit");
  property p_osc_off;
    (!o_osc_on) [*3] |-> !o_led_pulse && !o_integrating;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("activity while oscillator is off");
  property p_mask;
    $rose(o_irq) |-> $past(en_q[BIT_IRQ_MASK]);
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt raised while masked");
  property p_sleep;
    en_q[BIT_SLEEP] && o_irq |-> !$rose(o_integrating);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("new conversion while asleep on interrupt");
  property p_integ_len;
    $fell(o_integrating) && en_q[BIT_OSC_ON] && en_q[BIT_SENSE_EN]
      |-> ilen == 28'((256 - int'(it_q)) * P_STEP_CYCLES);
  endproperty
  a_integ_len: assert property (p_integ_len)
    else $error("integration length wrong");
  property p_pulse_gap;
    o_led_pulse |-> gap >= 16'(PULSE_CYCLES - 1);
  endproperty
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("led pulses too close");
  property p_clear;
    clr && !$fell(o_integrating) |=> !o_irq;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear command left interrupt pending");
  property p_latch;
    o_irq && !clr |=> o_irq;
  endproperty
  a_latch: assert property (p_latch)
    else $error("interrupt dropped without clear");
  property p_status;
    i_rd_en && i_rd_addr == ADDR_STATUS |=> o_rd_data[STAT_IRQ_BIT] == $past(o_irq);
  endproperty
  a_status: assert property (p_status)
    else $error("status pending bit differs from interrupt");
endmodule : pxs_checker
bind pxs_top pxs_checker #(.P_STEP_CYCLES(P_STEP_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
  .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
  .i_special_valid(i_special_valid), .i_special_code(i_special_code),
  .i_prox_data(i_prox_data), .o_osc_on(o_osc_on), .o_led_pulse(o_led_pulse),
  .o_integrating(o_integrating), .o_irq(o_irq)
);
`default_nettype wire

/* sim/tb_proximity_sequencer_config.sv */
// self-checking bench for the proximity sequencer
`default_nettype none
module tb_proximity_sequencer_config import pxs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PS = 4;
  logic clk, rst_n, wr_en, rd_en, sp_v, osc, led, integ, irq, integ_q;
  logic [4:0] wa, ra, sp_c;
  logic [7:0] wd, rd;
  logic [15:0] level, prox;
  int fails, n_tests, evals, pulses, cyc, t_eval, g0, g1, g2, e0;
  pxs_top #(.P_STEP_CYCLES(PS)) DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_wr_en(wr_en), .i_wr_addr(wa), .i_wr_data(wd),
    .i_rd_en(rd_en), .i_rd_addr(ra), .o_rd_data(rd), .i_special_valid(sp_v),
    .i_special_code(sp_c), .i_prox_data(prox), .o_osc_on(osc), .o_led_pulse(led),
    .o_integrating(integ), .o_irq(irq)
  );
  pxs_analog_model u_ana (.i_clk(clk), .i_level(level), .i_integrating(integ),
    .o_prox_data(prox));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // count cycles, conversion ends and led pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    integ_q <= integ;
    if (led === 1'b1) pulses <= pulses + 1;
    if (integ_q === 1'b1 && integ === 1'b0) begin
      evals <= evals + 1;
      t_eval <= cyc;
    end
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_en = 1'b1;
    wa = a;
    wd = d;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
  endtask : wr
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    ra = a;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    check(rd, exp);
  endtask : rdchk
  task automatic sp(input logic [4:0] c);
    @(posedge clk);
    #1;
    sp_v = 1'b1;
    sp_c = c;
    @(posedge clk);
    #1;
    sp_v = 1'b0;
  endtask : sp
  // bounded wait for n conversion ends, then let the flags settle
  task automatic wait_ev(input int n);
    int target;
    int k;
    target = evals + n;
    k = 0;
    while (evals < target && k < 40000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (evals < target) check(16'h0000, 16'h0001);
    repeat (2) @(posedge clk);
    #1;
  endtask : wait_ev
  task automatic quiet(input int n);
    e0 = evals;
    repeat (n) @(posedge clk);
    #1;
    check(16'(evals - e0), 16'h0000);
  endtask : quiet
  task automatic measure(output int g);
    wait_ev(1);
    g = t_eval;
    wait_ev(1);
    g = t_eval - g;
  endtask : measure
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // watchdog: about one and a half times the expected run of some 60k cycles
  initial begin
    #450_000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done;
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {rst_n, wr_en, rd_en, sp_v, wa, ra, wd, sp_c} = '0;
    level = 16'h0150;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 20; i++) rdchk(5'(i), (i == 2 || i == 3) ? 8'hFF : 8'h00);
    $display("test reset values done");
    wr(ADDR_FILTER, 8'hFF);
    wr(ADDR_CONFIG, 8'hFF);
    rdchk(ADDR_FILTER, MASK_FILTER);
    rdchk(ADDR_CONFIG, MASK_CONFIG);
    wr(ADDR_STATUS, 8'hFF);
    rdchk(ADDR_STATUS, 8'h00);
    wr(ADDR_ENABLE, 8'hFF);
    rdchk(ADDR_ENABLE, MASK_ENABLE);
    // from here on the host writes reserved bits as zero
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_FILTER, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    $display("test reserved bits done");
    wr(ADDR_ITIME, 8'hFE);
    wr(ADDR_PULSE, 8'h02);
    wr(ADDR_ENABLE, 8'h04);
    check(osc, 1'b0);
    quiet(100);
    wr(ADDR_ENABLE, 8'h01);
    check(osc, 1'b1);
    quiet(100);
    $display("test enable gating done");
    wr(ADDR_LOW_LO, 8'h00);
    wr(ADDR_LOW_HI, 8'h01);
    wr(ADDR_HIGH_LO, 8'h00);
    wr(ADDR_HIGH_HI, 8'h02);
    rdchk(ADDR_LOW_HI, 8'h01);
    rdchk(ADDR_HIGH_HI, 8'h02);
    wr(ADDR_FILTER, 8'h20);
    level = 16'h0050;
    wr(ADDR_ENABLE, 8'h25);
    wait_ev(1);
    check(irq, 1'b0);
    g0 = pulses;
    wait_ev(1);
    check(irq, 1'b1);
    check(16'(pulses - g0), 16'h0002);
    rdchk(ADDR_STATUS, 8'h22);
    sp(5'h06);
    check(irq, 1'b1);
    level = 16'h0150;
    sp(CMD_IRQ_CLEAR);
    check(irq, 1'b0);
    wait_ev(1);
    check(irq, 1'b0);
    level = 16'h0250;
    wait_ev(1);
    check(irq, 1'b0);
    wait_ev(1);
    check(irq, 1'b1);
    $display("test persistence done");
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_PULSE, 8'h00);
    wr(ADDR_FILTER, 8'h00);
    level = 16'h0150;
    sp(CMD_IRQ_CLEAR);
    wr(ADDR_ENABLE, 8'h05);
    wait_ev(2);
    check(irq, 1'b0);
    wr(ADDR_ENABLE, 8'h25);
    wait_ev(1);
    check(irq, 1'b1);
    sp(CMD_IRQ_CLEAR);
    $display("test mask and filter done");
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_WAIT_TIME, 8'h00);
    wr(ADDR_ENABLE, 8'h05);
    measure(g0);
    wr(ADDR_ENABLE, 8'h0D);
    measure(g1);
    wr(ADDR_CONFIG, 8'h02);
    measure(g2);
    check(16'(g1 - g0), 16'(256 * PS));
    check(16'(g2 - g0), 16'(256 * PS * 12));
    $display("test wait timing done");
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_ITIME, 8'hFF);
    sp(CMD_IRQ_CLEAR);
    wr(ADDR_ENABLE, 8'h65);
    wait_ev(1);
    check(irq, 1'b1);
    quiet(300);
    sp(CMD_IRQ_CLEAR);
    wait_ev(1);
    check(irq, 1'b1);
    $display("test sleep done");
    test_done;
  end
endmodule : tb_proximity_sequencer_config
`default_nettype wire
